// ===== logic/spwc_regs.svh
`ifndef SPWC_REGS_SVH
`define SPWC_REGS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define SPWC_OFS_CTRL 12'h000
`define SPWC_OFS_WAKE_EN 12'h004
`define SPWC_OFS_STATUS 12'h008
`define SPWC_OFS_MASK 12'h00C
`define SPWC_OFS_STATE 12'h010
`define SPWC_OFS_SMI_CMD 12'h014
`define SPWC_OFS_SLEEP 12'h018

// ==========================================================
// Control fields
`define SPWC_CTRL_W 3
`define SPWC_CTRL_ACPI 0
`define SPWC_CTRL_SLPBTN 1
`define SPWC_CTRL_SERB_MGMT 2
`define SPWC_CTRL_RST 3'h0

// ==========================================================
// Wake source bits, also the layout of the wake enable register
`define SPWC_WAKE_W 5
`define SPWC_WAKE_RING_A 0
`define SPWC_WAKE_RING_B 1
`define SPWC_WAKE_PME 2
`define SPWC_WAKE_RTC 3
`define SPWC_WAKE_LAN 4
`define SPWC_WAKE_EN_RST 5'h00

// ==========================================================
// Status and mask fields
`define SPWC_STAT_W 7
`define SPWC_ST_SMI_PWRBTN 0
`define SPWC_ST_SMI_ACPI_REQ 1
`define SPWC_ST_SCI_SHUTDOWN 2
`define SPWC_ST_SCI_SLEEP 3
`define SPWC_ST_SCI_WAKE 4
`define SPWC_ST_WAKE 5
`define SPWC_ST_POWER_ON 6
`define SPWC_STAT_RST 7'h00
`define SPWC_MASK_RST 7'h00

// ==========================================================
// Sleep command codes and timing
`define SPWC_SLP_S4 2'h1
`define SPWC_SLP_S5 2'h2
`define SPWC_DEBOUNCE_CYC 4

`endif

// ===== logic/spwc_pkg.sv
package spwc_pkg;

  // ========================================================
  // Power states
  typedef enum logic [1:0] {
    PS_OFF,
    PS_HIBERNATE,
    PS_POWER_UP,
    PS_ON
  } spwc_pstate_t;

endpackage : spwc_pkg

// ===== logic/spwc_btn_filter.sv
`timescale 1ns/1ps
module spwc_btn_filter #(
  parameter int N = 3,
  parameter int CYC = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw buttons, high while pressed
  input wire logic [N-1:0] raw,
  // Debounced level and press pulse
  output logic [N-1:0] level,
  output logic [N-1:0] press
);

  localparam int CW = $clog2(CYC + 1);

  // ========================================================
  // One debounce counter per button
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_btn
      logic [CW-1:0] cnt;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cnt <= '0;
          level[i] <= 1'b0;
          press[i] <= 1'b0;
        end else begin
          press[i] <= 1'b0;
          if (raw[i] == level[i]) begin
            cnt <= '0;
          end else if (cnt == CW'(CYC - 1)) begin
            cnt <= '0;
            level[i] <= raw[i];
            press[i] <= raw[i];
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule : spwc_btn_filter

// ===== logic/spwc_wake_latch.sv
`timescale 1ns/1ps
module spwc_wake_latch #(
  parameter int N = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic arm,
  input wire logic clear,
  // Sources and their effective enables
  input wire logic [N-1:0] src,
  input wire logic [N-1:0] en,
  // Latched sources
  output logic [N-1:0] hit,
  output logic any
);

  // ========================================================
  // Sticky per-source latch, a new event wins over clear
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_src
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          hit[i] <= 1'b0;
        end else if (arm && src[i] && en[i]) begin
          hit[i] <= 1'b1;
        end else if (clear) begin
          hit[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign any = |hit;

endmodule : spwc_wake_latch

// ===== logic/spwc_top.sv
// Function
// - Hard reset or power-on reset returns the block to legacy mode.
// - Software write raises SMI; handler then sets ACPI mode enable.
// - Only working, hibernate, soft-off and power-up states exist.
// - Legacy mode power button press raises SMI only.
// - ACPI mode press raises SCI shutdown request, no self power-off.
// - ACPI sleep-button press while running raises SCI sleep request.
// - ACPI sleep-button press while asleep wakes and raises SCI on request.
// - Press while off starts power-up; ON after power good and reset.
// - Power button always wakes, in both modes.
// - Serial port A ring wakes from hibernate or soft-off.
// - Serial port B ring wakes, unless port B is management port.
// - Card power management event may wake from hibernate or soft-off.
// - RTC alarm always wakes from hibernate.
// - Wake source enables are software programmable.
// - Up to three buttons: power, reset, optional NMI.
`timescale 1ns/1ps
`include "spwc_regs.svh"
module spwc_top #(
  parameter int DEBOUNCE_CYC = `SPWC_DEBOUNCE_CYC,
  parameter bit NMI_PRESENT = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Front panel buttons, high while pressed
  input wire logic power_button,
  input wire logic reset_button,
  input wire logic nmi_button,
  // Wake sources
  input wire logic serial_port_a_ring,
  input wire logic serial_port_b_ring,
  input wire logic pci_pme_n,
  input wire logic rtc_alarm,
  input wire logic lan_wake,
  // Power supply and platform reset
  input wire logic power_good,
  input wire logic platform_reset_n,
  output logic power_supply_on,
  output logic hard_reset_req,
  // Interrupts
  output logic smi,
  output logic sci,
  output logic nmi,
  output logic irq,
  // Current state
  output spwc_pkg::spwc_pstate_t power_state
);
  import spwc_pkg::*;

  localparam int SW = `SPWC_STAT_W;
  localparam int WW = `SPWC_WAKE_W;

  // ========================================================
  // Buttons
  logic [2:0] btn_press;
  logic pwr_press;
  logic rst_press;
  logic nmi_press;

  spwc_btn_filter #(
    .N(3),
    .CYC(DEBOUNCE_CYC)
  ) u_btn (
    .clk(pclk),
    .rst_n(presetn),
    .raw({nmi_button, reset_button, power_button}),
    .level(),
    .press(btn_press)
  );

  assign pwr_press = btn_press[0];
  assign rst_press = btn_press[1];
  assign nmi_press = btn_press[2] & NMI_PRESENT;

  // ========================================================
  // APB decode
  logic wr_acc;
  logic rd_setup;
  logic mapped;
  logic [SW-1:0] status;
  logic [SW-1:0] mask;
  logic [`SPWC_CTRL_W-1:0] ctrl;
  logic [WW-1:0] wake_en;
  logic [WW-1:0] wake_hit;
  logic wake_any;
  logic acpi_mode_enable;
  logic sleep_btn_cfg;
  logic serb_mgmt;
  logic sleeping;
  logic [31:0] rd_mux;

  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign acpi_mode_enable = ctrl[`SPWC_CTRL_ACPI];
  assign sleep_btn_cfg = ctrl[`SPWC_CTRL_SLPBTN];
  assign serb_mgmt = ctrl[`SPWC_CTRL_SERB_MGMT];
  assign sleeping = (power_state == PS_OFF) || (power_state == PS_HIBERNATE);

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `SPWC_OFS_CTRL: rd_mux[`SPWC_CTRL_W-1:0] = ctrl;
      `SPWC_OFS_WAKE_EN: rd_mux[WW-1:0] = wake_en;
      `SPWC_OFS_STATUS: rd_mux[SW-1:0] = status;
      `SPWC_OFS_MASK: rd_mux[SW-1:0] = mask;
      `SPWC_OFS_STATE: begin
        rd_mux[0] = (power_state == PS_ON);
        rd_mux[1] = (power_state == PS_HIBERNATE);
        rd_mux[2] = (power_state == PS_OFF);
        rd_mux[3] = (power_state == PS_POWER_UP);
        rd_mux[4] = acpi_mode_enable;
        rd_mux[5] = power_good;
        rd_mux[12:8] = wake_hit;
      end
      `SPWC_OFS_SMI_CMD: rd_mux = 32'h0000_0000;
      `SPWC_OFS_SLEEP: rd_mux = 32'h0000_0000;
      default: mapped = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // ========================================================
  // Control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `SPWC_CTRL_RST;
    end else begin
      if (wr_acc && paddr == `SPWC_OFS_CTRL) begin
        ctrl <= pwdata[`SPWC_CTRL_W-1:0];
      end
      if (rst_press || !platform_reset_n) begin
        ctrl[`SPWC_CTRL_ACPI] <= 1'b0;
      end
    end
  end

  // ========================================================
  // Wake enables and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= `SPWC_WAKE_EN_RST;
      mask <= `SPWC_MASK_RST;
    end else begin
      if (wr_acc && paddr == `SPWC_OFS_WAKE_EN) begin
        wake_en <= pwdata[WW-1:0];
      end
      if (wr_acc && paddr == `SPWC_OFS_MASK) begin
        mask <= pwdata[SW-1:0];
      end
    end
  end

  // ========================================================
  // Wake source collection
  logic [WW-1:0] wake_src;
  logic [WW-1:0] wake_eff;
  logic pwrup_start;

  assign wake_src[`SPWC_WAKE_RING_A] = serial_port_a_ring;
  assign wake_src[`SPWC_WAKE_RING_B] = serial_port_b_ring;
  assign wake_src[`SPWC_WAKE_PME] = !pci_pme_n;
  assign wake_src[`SPWC_WAKE_RTC] = rtc_alarm;
  assign wake_src[`SPWC_WAKE_LAN] = lan_wake;

  always_comb begin
    wake_eff = wake_en;
    wake_eff[`SPWC_WAKE_RING_B] = wake_en[`SPWC_WAKE_RING_B] && !serb_mgmt;
    wake_eff[`SPWC_WAKE_RTC] = wake_en[`SPWC_WAKE_RTC] ||
                               (power_state == PS_HIBERNATE);
  end

  spwc_wake_latch #(
    .N(WW)
  ) u_wake (
    .clk(pclk),
    .rst_n(presetn),
    .arm(sleeping),
    .clear(pwrup_start),
    .src(wake_src),
    .en(wake_eff),
    .hit(wake_hit),
    .any(wake_any)
  );

  // ========================================================
  // Power state machine
  spwc_pstate_t next_state;
  logic slp_wr;

  assign slp_wr = wr_acc && paddr == `SPWC_OFS_SLEEP;
  assign pwrup_start = sleeping && (pwr_press || wake_any);

  always_comb begin
    next_state = power_state;
    unique case (power_state)
      PS_OFF, PS_HIBERNATE: begin
        if (pwrup_start) begin
          next_state = PS_POWER_UP;
        end
      end
      PS_POWER_UP: begin
        if (power_good && platform_reset_n) begin
          next_state = PS_ON;
        end
      end
      PS_ON: begin
        if (slp_wr && pwdata[1:0] == `SPWC_SLP_S4) begin
          next_state = PS_HIBERNATE;
        end else if (slp_wr && pwdata[1:0] == `SPWC_SLP_S5) begin
          next_state = PS_OFF;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_state <= PS_OFF;
      power_supply_on <= 1'b0;
    end else begin
      power_state <= next_state;
      power_supply_on <= (next_state == PS_POWER_UP) || (next_state == PS_ON);
    end
  end

  // ========================================================
  // Event status, set wins over write-one-clear
  logic [SW-1:0] st_set;
  logic on_press;

  assign on_press = (power_state == PS_ON) && pwr_press;

  always_comb begin
    st_set = '0;
    st_set[`SPWC_ST_SMI_PWRBTN] = on_press && !acpi_mode_enable;
    st_set[`SPWC_ST_SMI_ACPI_REQ] = wr_acc && paddr == `SPWC_OFS_SMI_CMD;
    st_set[`SPWC_ST_SCI_SHUTDOWN] = on_press && acpi_mode_enable && !sleep_btn_cfg;
    st_set[`SPWC_ST_SCI_SLEEP] = on_press && acpi_mode_enable && sleep_btn_cfg;
    st_set[`SPWC_ST_SCI_WAKE] = sleeping && pwr_press &&
                                acpi_mode_enable && sleep_btn_cfg;
    st_set[`SPWC_ST_WAKE] = pwrup_start;
    st_set[`SPWC_ST_POWER_ON] = (power_state == PS_POWER_UP) && (next_state == PS_ON);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= `SPWC_STAT_RST;
    end else if (wr_acc && paddr == `SPWC_OFS_STATUS) begin
      status <= (status & ~pwdata[SW-1:0]) | st_set;
    end else begin
      status <= status | st_set;
    end
  end

  // ========================================================
  // Interrupt and pulse outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nmi <= 1'b0;
      hard_reset_req <= 1'b0;
    end else begin
      nmi <= nmi_press;
      hard_reset_req <= rst_press;
    end
  end

  assign smi = status[`SPWC_ST_SMI_PWRBTN] | status[`SPWC_ST_SMI_ACPI_REQ];
  assign sci = acpi_mode_enable & (status[`SPWC_ST_SCI_SHUTDOWN] |
               status[`SPWC_ST_SCI_SLEEP] | status[`SPWC_ST_SCI_WAKE]);
  assign irq = |(status & mask);

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_on_press;
    power_state == PS_ON && pwr_press;
  endsequence

  sequence s_asleep_press;
    sleeping && pwr_press;
  endsequence

  legacy_press_smi_a: assert property (
    s_on_press ##0 !acpi_mode_enable |=> smi && power_state == PS_ON)
    else $error("legacy press did not raise SMI");

  acpi_press_sci_a: assert property (
    s_on_press ##0 acpi_mode_enable && !sleep_btn_cfg && !rst_press && platform_reset_n
    |=> status[`SPWC_ST_SCI_SHUTDOWN] && sci && power_supply_on)
    else $error("ACPI press did not request shutdown");

  sleep_btn_sci_a: assert property (
    s_on_press ##0 acpi_mode_enable && sleep_btn_cfg
    |=> status[`SPWC_ST_SCI_SLEEP] && !status[`SPWC_ST_SCI_SHUTDOWN])
    else $error("sleep button did not request sleep");

  sleep_wake_sci_a: assert property (
    s_asleep_press ##0 acpi_mode_enable && sleep_btn_cfg
    |=> status[`SPWC_ST_SCI_WAKE] && status[`SPWC_ST_WAKE] &&
        power_state == PS_POWER_UP)
    else $error("sleep button did not wake");

  press_wakes_a: assert property (
    s_asleep_press |=> power_state == PS_POWER_UP ##0 power_supply_on)
    else $error("power button did not wake");

  reset_legacy_a: assert property (
    rst_press |=> !acpi_mode_enable)
    else $error("hard reset left ACPI mode set");

  pwrup_gate_a: assert property (
    power_state != PS_ON ##1 power_state == PS_ON
    |-> $past(power_good) && $past(platform_reset_n))
    else $error("ON without power good and reset");

  ring_b_block_a: assert property (
    $rose(wake_hit[`SPWC_WAKE_RING_B]) |-> !$past(serb_mgmt))
    else $error("port B ring woke while management port");

  rtc_wake_a: assert property (
    power_state == PS_HIBERNATE && rtc_alarm |-> ##[1:2] power_state == PS_POWER_UP)
    else $error("RTC alarm did not wake from hibernate");

  ring_a_wake_a: assert property (
    sleeping && serial_port_a_ring && wake_en[`SPWC_WAKE_RING_A]
    |-> ##[1:2] power_state == PS_POWER_UP)
    else $error("port A ring did not wake");

  supply_off_a: assert property (
    power_state == PS_ON && slp_wr && pwdata[1:0] == `SPWC_SLP_S5
    |=> power_state == PS_OFF && !power_supply_on)
    else $error("soft-off did not drop supply");

endmodule : spwc_top

// ===== tb/spwc_supply_model.sv
`timescale 1ns/1ps
module spwc_supply_model #(
  parameter int DELAY = 5
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Supply control and status
  input wire logic power_supply_on,
  output logic power_good,
  output logic platform_reset_n
);
  int cnt;

  // ==========================================================
  // Rails ramp, then power good and reset release together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      power_good <= 1'b0;
      platform_reset_n <= 1'b1;
    end else if (!power_supply_on) begin
      cnt <= 0;
      power_good <= 1'b0;
    end else if (cnt < DELAY) begin
      cnt <= cnt + 1;
      platform_reset_n <= 1'b0;
    end else begin
      power_good <= 1'b1;
      platform_reset_n <= 1'b1;
    end
  end
endmodule : spwc_supply_model

// ===== tb/system_power_wake_control_tb.sv
`timescale 1ns/1ps
`include "spwc_regs.svh"
module system_power_wake_control_tb;
  import spwc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic power_good, platform_reset_n, power_supply_on, hard_reset_req;
  logic smi, sci, nmi, irq, seen_hr, seen_nmi;
  logic [2:0] btn;
  logic [4:0] wsrc;
  spwc_pstate_t power_state;
  int n_errors, cmp_count;

  spwc_top #(.DEBOUNCE_CYC(1), .NMI_PRESENT(1'b1)) spwc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_button(btn[0]),
    .reset_button(btn[1]), .nmi_button(btn[2]), .serial_port_a_ring(wsrc[0]),
    .serial_port_b_ring(wsrc[1]), .pci_pme_n(~wsrc[2]), .rtc_alarm(wsrc[3]),
    .lan_wake(wsrc[4]), .power_good(power_good), .platform_reset_n(platform_reset_n),
    .power_supply_on(power_supply_on), .hard_reset_req(hard_reset_req),
    .smi(smi), .sci(sci), .nmi(nmi), .irq(irq), .power_state(power_state)
  );

  spwc_supply_model #(.DELAY(5)) spwc_supply_model_i (
    .pclk(pclk), .presetn(presetn), .power_supply_on(power_supply_on),
    .power_good(power_good), .platform_reset_n(platform_reset_n)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // One-cycle pulses caught here
  always @(posedge pclk) begin
    if (hard_reset_req === 1'b1) seen_hr <= 1'b1;
    if (nmi === 1'b1) seen_nmi <= 1'b1;
  end

  // ==========================================================
  // Access and compare tasks
  task automatic give_verdict;
    $display("comparisons %0d, errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0000_0000);
    chk($sformatf("reg %h", a), exp, rv & m);
  endtask : rd

  task automatic ws(input spwc_pstate_t s);
    for (int i = 0; i < 300 && power_state !== s; i++) @(posedge pclk);
    chk("power_state", 32'(s), 32'(power_state));
  endtask : ws

  task automatic press(input int b);
    btn[b] <= 1'b1;
    repeat (4) @(posedge pclk);
    btn[b] <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : press

  task automatic pulse(input int s);
    wsrc[s] <= 1'b1;
    @(posedge pclk);
    wsrc[s] <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : pulse

  task automatic wake_try(input logic [31:0] c, en, sl, input int s,
                          input spwc_pstate_t st, input logic w);
    wr(`SPWC_OFS_CTRL, c);
    wr(`SPWC_OFS_WAKE_EN, en);
    rd(`SPWC_OFS_WAKE_EN, en, 32'hFFFF_FFFF);
    wr(`SPWC_OFS_SLEEP, sl);
    chk("power_supply_on", 32'h0000_0000, 32'(power_supply_on));
    ws(st);
    pulse(s);
    if (w) begin
      ws(PS_ON);
      rd(`SPWC_OFS_STATUS, 32'h0000_0020, 32'h0000_0020);
    end else begin
      repeat (10) @(posedge pclk);
      ws(st);
      press(0);
      ws(PS_ON);
    end
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
  endtask : wake_try

  // ==========================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    give_verdict;
  end

  // ==========================================================
  // Test sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    btn = 3'h0;
    wsrc = 5'h00;
    {seen_hr, seen_nmi} = 2'b00;
    n_errors = 0;
    cmp_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPWC_OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SPWC_OFS_WAKE_EN, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SPWC_OFS_STATUS, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SPWC_OFS_MASK, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SPWC_OFS_STATE, 32'h0000_0004, 32'hFFFF_FFFF);
    apb(1'b0, 12'h100, 32'h0000_0000);
    chk("pslverr", 32'h0000_0001, 32'(re));
    chk("unmapped data", 32'h0000_0000, rv);
    apb(1'b1, 12'h100, 32'hFFFF_FFFF);
    chk("pslverr", 32'h0000_0001, 32'(re));
    wr(`SPWC_OFS_SLEEP, 32'h0000_0001);
    rd(`SPWC_OFS_STATE, 32'h0000_0004, 32'hFFFF_FFFF);
    press(0);
    ws(PS_ON);
    chk("power_supply_on", 32'h0000_0001, 32'(power_supply_on));
    rd(`SPWC_OFS_STATUS, 32'h0000_0040, 32'h0000_0040);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    press(0);
    rd(`SPWC_OFS_STATUS, 32'h0000_0001, 32'h0000_007F);
    chk("smi", 32'h0000_0001, 32'(smi));
    ws(PS_ON);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    chk("smi", 32'h0000_0000, 32'(smi));
    wr(`SPWC_OFS_SMI_CMD, 32'h0000_0001);
    rd(`SPWC_OFS_STATUS, 32'h0000_0002, 32'h0000_007F);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    wr(`SPWC_OFS_CTRL, 32'h0000_0001);
    press(0);
    rd(`SPWC_OFS_STATUS, 32'h0000_0004, 32'h0000_007F);
    chk("sci", 32'h0000_0001, 32'(sci));
    ws(PS_ON);
    chk("irq", 32'h0000_0000, 32'(irq));
    wr(`SPWC_OFS_MASK, 32'h0000_0004);
    chk("irq", 32'h0000_0001, 32'(irq));
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    chk("irq", 32'h0000_0000, 32'(irq));
    chk("sci", 32'h0000_0000, 32'(sci));
    wr(`SPWC_OFS_CTRL, 32'h0000_0003);
    press(0);
    rd(`SPWC_OFS_STATUS, 32'h0000_0008, 32'h0000_007F);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    wr(`SPWC_OFS_SLEEP, 32'h0000_0001);
    ws(PS_HIBERNATE);
    press(0);
    ws(PS_ON);
    rd(`SPWC_OFS_STATUS, 32'h0000_0010, 32'h0000_0010);
    rd(`SPWC_OFS_CTRL, 32'h0000_0000, 32'h0000_0001);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    wr(`SPWC_OFS_WAKE_EN, 32'h0000_0013);
    wr(`SPWC_OFS_SLEEP, 32'h0000_0002);
    chk("power_supply_on", 32'h0000_0000, 32'(power_supply_on));
    ws(PS_OFF);
    pulse(4);
    ws(PS_ON);
    wr(`SPWC_OFS_STATUS, 32'h0000_007F);
    wake_try(32'h0, 32'h1, 32'h2, 0, PS_OFF, 1'b1);
    wake_try(32'h0, 32'h2, 32'h1, 1, PS_HIBERNATE, 1'b1);
    wake_try(32'h4, 32'h2, 32'h2, 1, PS_OFF, 1'b0);
    wake_try(32'h0, 32'h4, 32'h2, 2, PS_OFF, 1'b1);
    wake_try(32'h0, 32'h0, 32'h1, 3, PS_HIBERNATE, 1'b1);
    wake_try(32'h0, 32'h0, 32'h2, 0, PS_OFF, 1'b0);
    wr(`SPWC_OFS_CTRL, 32'h0000_0001);
    press(1);
    chk("hard_reset_req", 32'h0000_0001, 32'(seen_hr));
    rd(`SPWC_OFS_CTRL, 32'h0000_0000, 32'h0000_0001);
    press(2);
    chk("nmi", 32'h0000_0001, 32'(seen_nmi));
    wr(`SPWC_OFS_CTRL, 32'h0000_0001);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`SPWC_OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
    rd(`SPWC_OFS_STATE, 32'h0000_0004, 32'hFFFF_FFFF);
    chk("power_supply_on", 32'h0000_0000, 32'(power_supply_on));
    give_verdict;
  end
endmodule : system_power_wake_control_tb
